// ---- phase_timer.sv ----
// phase timer: counts a loaded number of cycles and flags expiry
`timescale 1ns/1ps
module phase_timer #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    logic [WIDTH-1:0] remain_reg;

    initial begin
        if (WIDTH < 2) $error("phase_timer width too small");
    end

    // down counter; done is high in the last cycle of the phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            remain_reg <= '0;
        end else if (load) begin
            remain_reg <= count;
        end else if (remain_reg != '0) begin
            remain_reg <= remain_reg - WIDTH'(1);
        end
    end

    // done ignores load, so a reload driven from done forms no loop
    assign done = (remain_reg == WIDTH'(1));
endmodule // phase_timer

// ---- qsh_chk_assertions.sv ----
// checker: pin timing properties of the host bus port
`timescale 1ns/1ps
module qsh_chk
    import qsh_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic busStyle,
    input wire logic respValid,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic channelDSelectN,
    input wire logic [2:0] addr,
    input wire logic dataOe,
    input wire logic irqOutputOverride,
    input wire logic [3:0] channelIrq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic rw;
    // style is static, so one decode serves all properties
    assign rw = (busStyle == STYLE_RWLINE);
    sequence s_low2; !readStrobeN [*2] ##1 readStrobeN; endsequence
    sequence s_answer; ##2 respValid ##1 !respValid; endsequence
    property p_rdPulse; $fell(readStrobeN) |-> s_low2; endproperty
    a_rdPulse: assert property (p_rdPulse)
        else $error("read strobe width wrong");
    property p_answer; $fell(readStrobeN) |-> s_answer; endproperty
    a_answer: assert property (p_answer)
        else $error("read answer late or long");
    sequence s_oeHold; dataOe [*3] ##1 !dataOe; endsequence
    property p_wrData;
        !rw && $fell(writeStrobeN) |-> s_oeHold;
    endproperty
    a_wrData: assert property (p_wrData)
        else $error("write data not held");
    property p_addr;
        !readStrobeN || (!rw && !writeStrobeN) |-> $stable(addr);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address moved in strobe");
    property p_noDrive; dataOe |-> readStrobeN; endproperty
    a_noDrive: assert property (p_noDrive)
        else $error("host drives during read");
    property p_rwRead; rw |-> readStrobeN; endproperty
    a_rwRead: assert property (p_rwRead)
        else $error("read strobe moved");
    property p_rwSelD; rw |-> channelDSelectN; endproperty
    a_rwSelD: assert property (p_rwSelD)
        else $error("fourth select low");
    property p_rwIrq;
        rw && $past(rw) |-> channelIrq == 4'h0 && !irqOutputOverride;
    endproperty
    a_rwIrq: assert property (p_rwIrq)
        else $error("irq outputs not low");
endmodule // qsh_chk
bind quad_serial_host_bus_port qsh_chk i_qsh_chk (.sys_clk, .rst,
    .busStyle, .respValid, .readStrobeN, .writeStrobeN, .channelDSelectN,
    .addr, .dataOe, .irqOutputOverride, .channelIrq);

// ---- qsh_dev_model.sv ----
// behavioural model of the quad serial device behind the host port
`timescale 1ns/1ps
module qsh_dev_model
    import qsh_pkg::*;
(
    input wire logic sys_clk,
    input wire logic busStyle,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic [3:0] selN,
    input wire logic [2:0] addr,
    input wire logic [7:0] hostData,
    input wire logic hostOe,
    input wire logic irqOutputOverride,
    input wire logic [3:0] pending,
    output logic [7:0] devData,
    output logic [3:0] irqPins
);
    logic [7:0] regs [4][8];
    logic [1:0] ch, chH;
    logic [2:0] aH;
    logic [7:0] dH;
    logic [3:0] en;
    logic sel, rd, dirH, ovr;
    // power-up clears bit 3, so outputs start floating
    initial foreach (regs[i, j]) regs[i][j] = 8'h00;
    // channel decode and read detect per bus style
    always @* begin
        ch = {selN[2], selN[1]};
        sel = !selN[0];
        rd = sel && writeStrobeN;
        if (busStyle == STYLE_STROBE) begin
            for (int k = 0; k < 4; k++)
                if (!selN[k]) ch = 2'(k);
            sel = ($countones(selN) == 3);
            rd = sel && !readStrobeN;
        end
    end
    // snapshot the access at each rising clock edge while selected, so release
    // edges, whose pins settle in any order, still see clean values
    always @(posedge sys_clk) begin
        if (sel) begin
            chH <= ch;
            aH <= addr;
            dirH <= writeStrobeN;
            dH <= hostOe ? hostData : 8'hEE;
        end
    end
    // strobe style stores on the write strobe release
    always @(posedge writeStrobeN)
        if (busStyle == STYLE_STROBE && sel) regs[chH][aH] = dH;
    // read/write-line style stores on the select release
    always @(posedge selN[0])
        if (busStyle == STYLE_RWLINE && !dirH) regs[chH][aH] = dH;
    // a released bus shows a pattern that flips on every clock edge
    assign devData = rd ? regs[ch][addr] : 8'hA5 ^ {8{sys_clk}};
    assign ovr = (irqOutputOverride === 1'b1);
    // floating irq pins read inverted; line A is open drain with pull-up
    for (genvar g = 0; g < 4; g++) begin : g_irq
        assign en[g] = ovr || regs[g][MODEM_CTRL_OFFSET][IRQ_ENABLE_BIT];
        assign irqPins[g] = (busStyle == STYLE_STROBE) ?
            (en[g] ? pending[g] : !pending[g]) :
            (g == 0 ? !(|pending) : 1'b0);
    end
endmodule // qsh_dev_model

// ---- qsh_pkg.sv ----
// package for the host-side quad serial bus port controller
package qsh_pkg;
    // bus styles
    localparam logic STYLE_STROBE = 1'b1;
    localparam logic STYLE_RWLINE = 1'b0;
    // channel codes on the extra address pair
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;
    // register offset of the modem control register in each channel
    localparam logic [2:0] MODEM_CTRL_OFFSET = 3'h4;
    // field position of the interrupt output enable bit
    localparam int IRQ_ENABLE_BIT = 3;
    // strobe phase lengths in clock cycles (100 ns each)
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 200;
    localparam int HOLD_NS = 100;
    localparam int CLK_NS = 100;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);

    // bus request from the user side
    typedef struct packed {
        logic write;
        logic [1:0] channel;
        logic [2:0] addr;
        logic [7:0] data;
    } bus_req_s;

    // pins driven toward the device
    typedef struct packed {
        logic readStrobeN;
        logic writeStrobeN;
        logic [3:0] selectN;
        logic [2:0] addr;
    } bus_pins_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_STROBE = 2'b11,
        ST_HOLD = 2'b10
    } bus_state_e;
endpackage

// ---- quad_serial_host_bus_port.sv ----
// host controller driving a quad serial device over its parallel bus
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Functional notes
// - read/write-line style: host holds read strobe high permanently
// - read/write-line style: write strobe line is direction, high read
// - read/write-line style: host ties fourth select high
// - host keeps override low in read/write-line style
// ----------------------------------------------------------------------
module quad_serial_host_bus_port
    import qsh_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int OVERRIDE_TIE = 0 // 0 none, 1 tie high, 2 tie low
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic busStyle,
    input wire logic reqValid,
    input wire qsh_pkg::bus_req_s req,
    output logic reqReady,
    output logic respValid,
    output logic [7:0] respData,
    input wire logic overrideRequest,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic channelASelectN,
    output logic channelBSelectN,
    output logic channelCSelectN,
    output logic channelDSelectN,
    output logic [2:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic irqOutputOverride,
    input wire logic channelAIrq,
    input wire logic channelBIrq,
    input wire logic channelCIrq,
    input wire logic channelDIrq,
    output logic deviceIrq,
    output logic [3:0] channelIrq
);
    import qsh_pkg::*;

    initial begin
        if (DATA_WIDTH != 8) $error("data bus must be 8 bits");
        if (OVERRIDE_TIE > 2) $error("bad override tie option");
    end

    // ------------------------------------------------------------------
    // pin encoding
    // ------------------------------------------------------------------
    // active-low one-hot select in strobe style
    function automatic logic [3:0] select_pins(input logic style,
                                               input logic [1:0] ch);
        logic [3:0] pins;
        pins = 4'hF;
        if (style == STYLE_STROBE) begin
            pins[ch] = 1'b0;
        end else begin
            pins[0] = 1'b0;
            pins[1] = ch[0];
            pins[2] = ch[1];
            pins[3] = 1'b1;
        end
        return pins;
    endfunction

    bus_state_e state_reg;
    bus_req_s latched_reg;
    logic styleLatched_reg;
    logic timerLoad;
    logic [3:0] timerCount;
    logic phaseDone;
    logic [3:0] irqEnable_reg;
    logic [3:0] irqMask;

    phase_timer #(.WIDTH(4)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(timerLoad),
        .count(timerCount),
        .done(phaseDone)
    );

    // ------------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------------
    // each phase reloads the timer on entry
    always_comb begin
        timerLoad = 1'b0;
        timerCount = SETUP_CNT;
        case (state_reg)
            ST_IDLE: begin
                timerLoad = reqValid;
                timerCount = SETUP_CNT;
            end
            ST_SETUP: begin
                timerLoad = phaseDone;
                timerCount = STROBE_CNT;
            end
            ST_STROBE: begin
                timerLoad = phaseDone;
                timerCount = HOLD_CNT;
            end
            default: begin
                timerLoad = 1'b0;
                timerCount = SETUP_CNT;
            end
        endcase
    end

    // style is sampled per transaction so strobe and select pins never change mid cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            latched_reg <= '0;
            styleLatched_reg <= STYLE_STROBE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (reqValid) begin
                        latched_reg <= req;
                        styleLatched_reg <= busStyle;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: if (phaseDone) state_reg <= ST_STROBE;
                ST_STROBE: if (phaseDone) state_reg <= ST_HOLD;
                ST_HOLD: if (phaseDone) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // bus pins
    // ------------------------------------------------------------------
    // select and address stand from setup through hold
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {channelDSelectN, channelCSelectN, channelBSelectN,
             channelASelectN} <= 4'hF;
            addr <= 3'h0;
            reqReady <= 1'b0;
        end else begin
            reqReady <= (state_reg == ST_IDLE) && !reqValid &&
                        !(state_reg == ST_HOLD);
            if (state_reg == ST_IDLE && reqValid) begin
                {channelDSelectN, channelCSelectN, channelBSelectN,
                 channelASelectN} <= select_pins(busStyle, req.channel);
                addr <= req.addr;
            end else if (state_reg == ST_HOLD && phaseDone) begin
                {channelDSelectN, channelCSelectN, channelBSelectN,
                 channelASelectN} <= 4'hF;
            end
        end
    end

    // strobes: strobe style pulses one line; rw-line style sets direction
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            readStrobeN <= 1'b1;
            writeStrobeN <= 1'b1;
        end else begin
            readStrobeN <= 1'b1;
            if (styleLatched_reg == STYLE_STROBE) begin
                writeStrobeN <= 1'b1;
                if ((state_reg == ST_SETUP && phaseDone) ||
                    (state_reg == ST_STROBE && !phaseDone)) begin
                    readStrobeN <= latched_reg.write;
                    writeStrobeN <= !latched_reg.write;
                end
            end else if (state_reg != ST_IDLE) begin
                writeStrobeN <= !latched_reg.write;
            end else begin
                writeStrobeN <= 1'b1;
            end
        end
    end

    // write data drives from setup to hold; floats otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dataOut <= 8'h00;
            dataOe <= 1'b0;
        end else if (state_reg == ST_IDLE && reqValid && req.write) begin
            dataOut <= req.data;
            dataOe <= 1'b1;
        end else if (state_reg == ST_HOLD && phaseDone) begin
            dataOe <= 1'b0;
        end
    end

    // read data is captured at the end of the strobe phase, where strobe style raises the read strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            respValid <= 1'b0;
            respData <= 8'h00;
        end else begin
            respValid <= 1'b0;
            if (state_reg == ST_STROBE && phaseDone) begin
                respValid <= 1'b1;
                respData <= latched_reg.write ? 8'h00 : dataIn;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt handling
    // ------------------------------------------------------------------
    // override pin: forced low in rw-line style; build tie wins otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqOutputOverride <= 1'b0;
        end else if (busStyle == STYLE_RWLINE) begin
            irqOutputOverride <= 1'b0;
        end else if (OVERRIDE_TIE == 1) begin
            irqOutputOverride <= 1'b1;
        end else if (OVERRIDE_TIE == 2) begin
            irqOutputOverride <= 1'b0;
        end else begin
            irqOutputOverride <= overrideRequest;
        end
    end

    // shadow of each channel's output enable bit, learnt from our own
    // writes; the host cannot read it back from the pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqEnable_reg <= 4'h0;
        end else if (state_reg == ST_IDLE && reqValid && req.write &&
                     req.addr == MODEM_CTRL_OFFSET) begin
            irqEnable_reg[req.channel] <= req.data[IRQ_ENABLE_BIT];
        end
    end

    // a floated line reads as noise, so only driven lines are trusted
    assign irqMask = irqEnable_reg | {4{irqOutputOverride}};

    // disabled channel lines float and are masked;
    // rw-line style: channel A carries the open-drain request, active low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            channelIrq <= 4'h0;
            deviceIrq <= 1'b0;
        end else if (busStyle == STYLE_STROBE) begin
            channelIrq <= {channelDIrq, channelCIrq, channelBIrq,
                           channelAIrq} & irqMask;
            deviceIrq <= 1'b0;
        end else begin
            channelIrq <= 4'h0;
            deviceIrq <= !channelAIrq;
        end
    end
endmodule // quad_serial_host_bus_port

// ---- tb_top.sv ----
// self-checking bench: host bus port against the device model
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("Error %0t: %h vs %h", $time, g, e); end end
module tb_top;
    import qsh_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic busStyle = STYLE_STROBE;
    logic reqValid = 1'b0;
    bus_req_s req = '0;
    logic overrideRequest = 1'b0;
    logic [3:0] pending = 4'h0;
    logic reqReady, respValid, readStrobeN, writeStrobeN, dataOe;
    logic irqOutputOverride, deviceIrq;
    logic [3:0] channelIrq, irqPins;
    wire [3:0] selN;
    logic [2:0] addr;
    logic [7:0] respData, dataIn, dataOut, rdata;
    int errors = 0;
    int compares = 0;
    always #50 sys_clk = ~sys_clk;
    quad_serial_host_bus_port i_quad_serial_host_bus_port (.sys_clk, .rst,
        .busStyle, .reqValid, .req, .reqReady, .respValid, .respData,
        .overrideRequest, .readStrobeN, .writeStrobeN,
        .channelASelectN(selN[0]), .channelBSelectN(selN[1]),
        .channelCSelectN(selN[2]), .channelDSelectN(selN[3]), .addr,
        .dataIn, .dataOut, .dataOe, .irqOutputOverride,
        .channelAIrq(irqPins[0]), .channelBIrq(irqPins[1]),
        .channelCIrq(irqPins[2]), .channelDIrq(irqPins[3]), .deviceIrq,
        .channelIrq);
    qsh_dev_model i_qsh_dev_model (.sys_clk, .busStyle, .readStrobeN,
        .writeStrobeN, .selN, .addr, .hostData(dataOut), .hostOe(dataOe),
        .irqOutputOverride, .pending, .devData(dataIn), .irqPins);
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset(input logic style);
        @(negedge sys_clk);
        rst = 1'b1;
        busStyle = style;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        `CHK(reqReady, 1'b1)
    endtask
    // request held until the answer, so it cannot be taken twice
    task automatic access(input logic w, input logic [1:0] c,
            input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        req = '{w, c, a, d};
        reqValid = 1'b1;
        while (respValid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        reqValid = 1'b0;
        rdata = respData;
        `CHK(reqReady, 1'b0)
        if (n == 20) begin
            errors++;
            $display("Error %0t: no answer", $time);
            end_of_test();
        end
    endtask
    // every channel at both address ends, all writes before any read
    task automatic bus_all(input logic [7:0] s);
        for (int c = 0; c < 4; c++)
            for (int a = 0; a < 8; a += 7)
                access(1'b1, 2'(c), 3'(a), s ^ 8'(c * 16 + a));
        for (int c = 0; c < 4; c++)
            for (int a = 0; a < 8; a += 7) begin
                access(1'b0, 2'(c), 3'(a), 8'h00);
                `CHK(rdata, s ^ 8'(c * 16 + a))
            end
    endtask
    task automatic irq_wait(input logic [4:0] m, input logic [4:0] e);
        int n;
        n = 0;
        while (({deviceIrq, channelIrq} & m) !== e && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 10) begin
            errors++;
            $display("Error %0t: interrupt state stuck", $time);
            end_of_test();
        end
    endtask
    task automatic t_strobe_irq();
        do_reset(STYLE_STROBE);
        @(negedge sys_clk);
        overrideRequest = 1'b1;
        pending = 4'b0100;
        irq_wait(5'h0F, 5'h04);
        `CHK(channelIrq, 4'b0100)
        `CHK(irqOutputOverride, 1'b1)
        access(1'b1, CH_B, MODEM_CTRL_OFFSET, 8'(1 << IRQ_ENABLE_BIT));
        overrideRequest = 1'b0;
        pending = 4'b0010;
        irq_wait(5'h02, 5'h02);
        `CHK(channelIrq, 4'b0010)
        pending = 4'h0;
        irq_wait(5'h02, 5'h00);
        `CHK(channelIrq, 4'h0)
        $display("test strobe_irq done");
    endtask
    task automatic t_rw_irq();
        do_reset(STYLE_RWLINE);
        @(negedge sys_clk);
        overrideRequest = 1'b1;
        pending = 4'b1000;
        irq_wait(5'h1F, 5'h10);
        `CHK(deviceIrq, 1'b1)
        `CHK(channelIrq, 4'h0)
        `CHK(irqOutputOverride, 1'b0)
        pending = 4'h0;
        irq_wait(5'h10, 5'h00);
        `CHK(deviceIrq, 1'b0)
        $display("test rwline_irq done");
    endtask
    initial begin
        do_reset(STYLE_STROBE);
        bus_all(8'h3C);
        $display("test strobe_bus done");
        do_reset(STYLE_RWLINE);
        bus_all(8'hC3);
        `CHK(readStrobeN, 1'b1)
        $display("test rwline_bus done");
        t_strobe_irq();
        t_rw_irq();
        end_of_test();
    end
endmodule // tb_top
